/* File: rtl/bfa_annunciator.v */
// barrier fault annunciator: leds, status codes, lcd, buzzer, irq regs
// assumes inputs synchronous to I_CLK; fault events one-cycle pulses
`timescale 1ns/1ps
`include "bfa_consts.vh"

module bfa_annunciator #(
    parameter TICK_CYCLES = `BFA_TICK_TIME_US * `BFA_CLK_MHZ
) (
    input  wire        I_CLK,
    input  wire        I_RST_N,
    // field inputs, high while activated
    input  wire        I_LOOP_DETECT_IN,
    input  wire        I_AUX_IN,
    input  wire        I_LOCK_STOP_IN,
    input  wire        I_LATCHING_TRIGGER_IN,
    input  wire        I_MOMENTARY_TRIGGER_IN,
    input  wire        I_RAISE_IN,
    input  wire        I_LOWER_IN,
    // barrier state
    input  wire        I_ARM_LOWERED,
    input  wire        I_ARM_RAISING,
    input  wire        I_ARM_LOWERING,
    // status levels
    input  wire        I_LIGHT_OVERRIDE,
    input  wire        I_MAINS_OK,
    input  wire        I_BATT_LOW,
    input  wire        I_MULTI_COLLISION,
    input  wire [1:0]  I_BATT_LEVEL,
    // lcd field sources
    input  wire        I_AUTOLOWER_SEL,
    input  wire        I_AUTOLOWER_OVR,
    input  wire [7:0]  I_AUTOLOWER_TIME,
    input  wire [1:0]  I_LIGHT_MODE,
    input  wire [7:0]  I_COURTESY_TIME,
    // fault event pulses, one bit per buzzer condition
    input  wire [13:0] I_FAULT_EVT,
    // register port
    input  wire [7:0]  I_ADDR,
    input  wire [31:0] I_WDATA,
    input  wire        I_WR,
    input  wire        I_RD,
    output reg  [31:0] O_RDATA,
    // indicators
    output reg         O_LED_LOOP_GRN,
    output reg         O_LED_AUX_GRN,
    output reg         O_LED_LOCK_GRN,
    output reg         O_LED_LATCH_RED,
    output reg         O_LED_MOMENT_RED,
    output reg         O_LED_RAISE_RED,
    output reg         O_LED_LOWER_RED,
    output reg         O_LED_STATUS,
    // lcd
    output reg  [2:0]  O_BATT_BARS,
    output reg         O_BATT_ICON,
    output reg         O_MAINS_SOLID,
    output reg         O_MAINS_HOLLOW,
    output reg  [1:0]  O_AUTOLOWER_MODE,
    output reg  [7:0]  O_AUTOLOWER_TIME,
    output reg  [1:0]  O_LIGHT_FIELD_MODE,
    output reg  [7:0]  O_LIGHT_FIELD_TIME,
    // buzzer, inhibit, collision, interrupt
    output reg         O_BUZZER,
    output reg         O_ARM_INHIBIT,
    output reg         O_COLLISION,
    output reg         O_IRQ
);

    localparam NC = `BFA_NCOND;

    // buzzer pattern states, one-hot
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_ON   = 4'h2;
    localparam [3:0] ST_OFF  = 4'h4;
    localparam [3:0] ST_GAP  = 4'h8;

    // per-condition tables, five bits of seconds each, index 0 lowest
    localparam [69:0] DUR_VEC = {
        5'd`BFA_STALL_S, {6{5'd`BFA_LONG_S}},
        5'd`BFA_SHORT_S, 5'd`BFA_SHORT_S,
        {5{5'd`BFA_LONG_S}}};
    // beeps per group, three bits each
    localparam [41:0] BEEP_VEC = {
        3'd`BFA_BEEPS_FOUR, {4{3'd`BFA_BEEPS_FIVE}}, 3'd`BFA_BEEPS_ONE,
        3'd`BFA_BEEPS_TWO, 3'd`BFA_BEEPS_THREE, {3{3'd`BFA_BEEPS_ONE}},
        3'd`BFA_BEEPS_FIVE, 3'd`BFA_BEEPS_THREE, 3'd`BFA_BEEPS_CONT};
    // conditions that stop the arm; battery, mains and break-in do not
    localparam [13:0] INHIBIT_MASK = 14'h3F7C;
    // conditions using short beeps
    localparam [13:0] SHORT_MASK = 14'h0040;

    // shared tick divider
    reg  [16:0] div_cnt;             // cycles within one millisecond
    reg         ms_tick;             // one-cycle pulse each millisecond
    reg  [9:0]  sec_cnt;             // milliseconds within one second
    reg         sec_tick;            // one-cycle pulse each second

    // the only divider: every flash and beep time counts its ticks, so
    // shortening TICK_CYCLES scales all of them together
    always @(posedge I_CLK) begin
        if (!I_RST_N) begin
            div_cnt  <= 17'h0_0000;
            ms_tick  <= 1'b0;
            sec_cnt  <= 10'h000;
            sec_tick <= 1'b0;
        end else begin
            ms_tick  <= 1'b0;
            sec_tick <= 1'b0;
            if (div_cnt == TICK_CYCLES[16:0] - 17'h0_0001) begin
                div_cnt <= 17'h0_0000;
                ms_tick <= 1'b1;
                if (sec_cnt == `BFA_MS_PER_S - 1) begin
                    sec_cnt  <= 10'h000;
                    sec_tick <= 1'b1;
                end else begin
                    sec_cnt <= sec_cnt + 10'h001;
                end
            end else begin
                div_cnt <= div_cnt + 17'h0_0001;
            end
        end
    end

    // flash phases for the status led and lcd icons
    reg  [9:0]  slow_cnt;            // ms within slow half period
    reg         slow_ph;             // slow flash phase
    reg  [9:0]  fast_cnt;            // ms within fast half period
    reg         fast_ph;             // fast flash phase
    reg  [7:0]  slot_ms;             // ms within one code slot
    reg  [2:0]  slot_idx;            // slot number within code period

    // free-running phases; the code period is whole slots long
    always @(posedge I_CLK) begin
        if (!I_RST_N) begin
            slow_cnt <= 10'h000;
            slow_ph  <= 1'b0;
            fast_cnt <= 10'h000;
            fast_ph  <= 1'b0;
            slot_ms  <= 8'h00;
            slot_idx <= 3'h0;
        end else if (ms_tick) begin
            if (slow_cnt == `BFA_SLOW_HALF_MS - 1) begin
                slow_cnt <= 10'h000;
                slow_ph  <= ~slow_ph;
            end else begin
                slow_cnt <= slow_cnt + 10'h001;
            end
            if (fast_cnt == `BFA_FAST_HALF_MS - 1) begin
                fast_cnt <= 10'h000;
                fast_ph  <= ~fast_ph;
            end else begin
                fast_cnt <= fast_cnt + 10'h001;
            end
            if (slot_ms == `BFA_CODE_SLOT_MS - 1) begin
                slot_ms <= 8'h00;
                if (slot_idx == `BFA_CODE_PERIOD_MS / `BFA_CODE_SLOT_MS - 1)
                    slot_idx <= 3'h0;
                else
                    slot_idx <= slot_idx + 3'h1;
            end else begin
                slot_ms <= slot_ms + 8'h01;
            end
        end
    end

    // flash count for the status code; lowest count wins when several hold
    wire [2:0]  code_n = I_LIGHT_OVERRIDE  ? 3'h1 :
                         !I_MAINS_OK       ? 3'h2 :
                         I_BATT_LOW        ? 3'h3 :
                         I_MULTI_COLLISION ? 3'h4 : 3'h0;

    // per-condition seconds timers, restarted by each new event
    reg  [4:0]  tmr [0:NC-1];
    wire [13:0] active;
    genvar g;
    generate
        for (g = 0; g < NC; g = g + 1) begin : cond
            always @(posedge I_CLK) begin
                if (!I_RST_N)
                    tmr[g] <= 5'h00;
                else if (I_FAULT_EVT[g])
                    tmr[g] <= DUR_VEC[g*5 +: 5];
                else if (sec_tick && tmr[g] != 5'h00)
                    tmr[g] <= tmr[g] - 5'h01;
            end
            assign active[g] = (tmr[g] != 5'h00);
        end
    endgenerate

    // priority pick: lowest index, which is the lowest priority number
    reg  [3:0]  sel;
    reg         sel_vld;
    integer     k;
    always @* begin
        sel     = 4'h0;
        sel_vld = 1'b0;
        for (k = NC - 1; k >= 0; k = k - 1) begin
            if (active[k]) begin
                sel     = k[3:0];
                sel_vld = 1'b1;
            end
        end
    end

    // pattern parameters of the chosen condition
    wire [2:0]  beeps  = BEEP_VEC[sel*3 +: 3];
    wire        shrt   = SHORT_MASK[sel];
    wire [10:0] on_ms  = shrt ? 11'd`BFA_SHORT_ON_MS : 11'd`BFA_BEEP_ON_MS;
    wire [10:0] off_ms = shrt ? 11'd`BFA_SHORT_OFF_MS : 11'd`BFA_BEEP_OFF_MS;

    // buzzer pattern machine
    reg  [3:0]  state;
    reg  [3:0]  cur_sel;             // condition the pattern belongs to
    reg  [10:0] pat_ms;              // ms spent in the current state
    reg  [2:0]  beep_n;              // beeps finished in this group

    // a change of winner restarts the pattern so no group is mixed
    always @(posedge I_CLK) begin
        if (!I_RST_N) begin
            state   <= ST_IDLE;
            cur_sel <= 4'h0;
            pat_ms  <= 11'h000;
            beep_n  <= 3'h0;
        end else if (!sel_vld || sel != cur_sel) begin
            state   <= sel_vld ? ST_ON : ST_IDLE;
            cur_sel <= sel;
            pat_ms  <= 11'h000;
            beep_n  <= 3'h0;
        end else begin
            case (state)
                ST_IDLE: state <= ST_ON; // counters zeroed on the way in
                ST_ON: begin
                    // zero beeps means a continuous tone
                    if (beeps != 3'h0 && ms_tick) begin
                        if (pat_ms == on_ms - 11'h001) begin
                            state  <= ST_OFF;
                            pat_ms <= 11'h000;
                            beep_n <= beep_n + 3'h1;
                        end else begin
                            pat_ms <= pat_ms + 11'h001;
                        end
                    end
                end
                ST_OFF: begin
                    if (ms_tick) begin
                        if (pat_ms == off_ms - 11'h001) begin
                            state  <= (beep_n == beeps) ? ST_GAP : ST_ON;
                            pat_ms <= 11'h000;
                        end else begin
                            pat_ms <= pat_ms + 11'h001;
                        end
                    end
                end
                ST_GAP: begin
                    if (ms_tick) begin
                        if (pat_ms == `BFA_GROUP_GAP_MS - 1) begin
                            state  <= ST_ON;
                            pat_ms <= 11'h000;
                            beep_n <= 3'h0;
                        end else begin
                            pat_ms <= pat_ms + 11'h001;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // interrupt registers
    reg  [13:0] int_status;          // sticky event bits
    reg  [13:0] int_enable;          // mask onto O_IRQ
    wire        wr_clr = I_WR && (I_ADDR == `BFA_REG_INT_CLEAR);
    wire [13:0] clr    = wr_clr ? I_WDATA[13:0] : 14'h0000;

    // a new event in the clear cycle survives: set wins over clear
    always @(posedge I_CLK) begin
        if (!I_RST_N) begin
            int_status <= 14'h0000;
            int_enable <= `BFA_INT_ENABLE_RST;
            O_RDATA    <= 32'h0000_0000;
            O_IRQ      <= 1'b0;
        end else begin
            int_status <= (int_status & ~clr) | I_FAULT_EVT;
            if (I_WR && I_ADDR == `BFA_REG_INT_ENABLE)
                int_enable <= I_WDATA[13:0];
            O_IRQ <= |(int_status & int_enable);
            // read data stands only in the cycle after the strobe
            O_RDATA <= 32'h0000_0000;
            if (I_RD) begin
                case (I_ADDR)
                    `BFA_REG_INT_STATUS: O_RDATA <= {18'h0_0000, int_status};
                    `BFA_REG_INT_ENABLE: O_RDATA <= {18'h0_0000, int_enable};
                    `BFA_REG_ACTIVE:     O_RDATA <= {18'h0_0000, active};
                    default:             O_RDATA <= 32'h0000_0000;
                endcase
            end
        end
    end

    // registered indicator, lcd and buzzer outputs
    always @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_LED_LOOP_GRN     <= 1'b0;
            O_LED_AUX_GRN      <= 1'b0;
            O_LED_LOCK_GRN     <= 1'b0;
            O_LED_LATCH_RED    <= 1'b0;
            O_LED_MOMENT_RED   <= 1'b0;
            O_LED_RAISE_RED    <= 1'b0;
            O_LED_LOWER_RED    <= 1'b0;
            O_LED_STATUS       <= 1'b0;
            O_BATT_BARS        <= 3'h0;
            O_BATT_ICON        <= 1'b0;
            O_MAINS_SOLID      <= 1'b0;
            O_MAINS_HOLLOW     <= 1'b0;
            O_AUTOLOWER_MODE   <= 2'h0;
            O_AUTOLOWER_TIME   <= 8'h00;
            O_LIGHT_FIELD_MODE <= 2'h0;
            O_LIGHT_FIELD_TIME <= 8'h00;
            O_BUZZER           <= 1'b0;
            O_ARM_INHIBIT      <= 1'b0;
            O_COLLISION        <= 1'b0;
        end else begin
            // normally-closed inputs: green dark once activated
            O_LED_LOOP_GRN   <= ~I_LOOP_DETECT_IN;
            O_LED_AUX_GRN    <= ~I_AUX_IN;
            O_LED_LOCK_GRN   <= ~I_LOCK_STOP_IN;
            // normally-open inputs: red lit while present
            O_LED_LATCH_RED  <= I_LATCHING_TRIGGER_IN;
            O_LED_MOMENT_RED <= I_MOMENTARY_TRIGGER_IN;
            O_LED_RAISE_RED  <= I_RAISE_IN;
            O_LED_LOWER_RED  <= I_LOWER_IN;
            // a fault code takes the led over from the motion display
            if (code_n != 3'h0)
                O_LED_STATUS <= (slot_idx < code_n) &&
                                (slot_ms < `BFA_CODE_ON_MS);
            else if (I_ARM_RAISING)
                O_LED_STATUS <= slow_ph;
            else if (I_ARM_LOWERING)
                O_LED_STATUS <= fast_ph;
            else
                O_LED_STATUS <= ~I_ARM_LOWERED;
            // battery: level 0 empty, 1 half, 2 or 3 full
            O_BATT_ICON <= (I_BATT_LEVEL != 2'h0) | slow_ph;
            case (I_BATT_LEVEL)
                2'h0:    O_BATT_BARS <= 3'h0;
                2'h1:    O_BATT_BARS <= 3'h2;
                default: O_BATT_BARS <= 3'h4;
            endcase
            O_MAINS_SOLID  <= I_MAINS_OK;
            O_MAINS_HOLLOW <= ~I_MAINS_OK & slow_ph;
            // autolower field: 0 off, 1 override code, 2 countdown
            if (!I_AUTOLOWER_SEL)
                O_AUTOLOWER_MODE <= 2'h0;
            else if (I_AUTOLOWER_OVR)
                O_AUTOLOWER_MODE <= 2'h1;
            else
                O_AUTOLOWER_MODE <= 2'h2;
            O_AUTOLOWER_TIME <= (I_AUTOLOWER_SEL && !I_AUTOLOWER_OVR) ?
                                I_AUTOLOWER_TIME : 8'h00;
            // light field mirrors the mode; time only in courtesy mode
            O_LIGHT_FIELD_MODE <= I_LIGHT_MODE;
            O_LIGHT_FIELD_TIME <= (I_LIGHT_MODE == 2'h0) ?
                                  I_COURTESY_TIME : 8'h00;
            O_BUZZER      <= (state == ST_ON) && sel_vld && sel == cur_sel;
            O_ARM_INHIBIT <= |(active & INHIBIT_MASK);
            O_COLLISION   <= active[`BFA_C_STALL];
        end
    end

endmodule // bfa_annunciator

/* File: rtl/bfa_consts.vh */
// barrier fault annunciator constants: offsets, layouts, timings
// assumes one 125 MHz clock; times count divider ms or s ticks
`ifndef BFA_CONSTS_VH
`define BFA_CONSTS_VH

// clock and tick divider
`define BFA_CLK_MHZ          125
`define BFA_TICK_TIME_US     1000
`define BFA_MS_PER_S         1000

// status led flash rates in milliseconds (values not given, plain defaults)
`define BFA_SLOW_HALF_MS     500
`define BFA_FAST_HALF_MS     125
`define BFA_CODE_PERIOD_MS   2000
`define BFA_CODE_SLOT_MS     250
`define BFA_CODE_ON_MS       125

// buzzer pattern times in milliseconds (values not given, plain defaults)
`define BFA_BEEP_ON_MS       200
`define BFA_BEEP_OFF_MS      200
`define BFA_SHORT_ON_MS      80
`define BFA_SHORT_OFF_MS     120
`define BFA_GROUP_GAP_MS     1000

// buzzer durations in seconds
`define BFA_LONG_S           30
`define BFA_SHORT_S          5
`define BFA_STALL_S          10

// beep counts per group; zero means a continuous tone
`define BFA_BEEPS_CONT       0
`define BFA_BEEPS_ONE        1
`define BFA_BEEPS_TWO        2
`define BFA_BEEPS_THREE      3
`define BFA_BEEPS_FOUR       4
`define BFA_BEEPS_FIVE       5

// number of buzzer conditions; bit order of the event vector is priority
`define BFA_NCOND            14
`define BFA_C_BREAK_IN       0
`define BFA_C_BATT_LOW       1
`define BFA_C_AUX_OVL        2
`define BFA_C_HOLIDAY        3
`define BFA_C_ESTOP          4
`define BFA_C_TIMEBAR        5
`define BFA_C_NO_LIMITS      6
`define BFA_C_MAINS_FAIL     7
`define BFA_C_LOOP_BROKEN    8
`define BFA_C_POS_SENSOR     9
`define BFA_C_FUSE           10
`define BFA_C_MOTOR          11
`define BFA_C_BRIDGE         12
`define BFA_C_STALL          13

// register byte offsets
`define BFA_REG_INT_STATUS   8'h00
`define BFA_REG_INT_CLEAR    8'h04
`define BFA_REG_INT_ENABLE   8'h08
`define BFA_REG_ACTIVE       8'h0C
`define BFA_INT_ENABLE_RST   14'h0000

`endif

/* File: tb/bfa_annunciator_chk.sv */
// checker on the ports of the barrier fault annunciator
// assumes binding to bfa_annunciator, same clock
`timescale 1ns/1ps
`include "bfa_consts.vh"
module bfa_chk (
    input wire        I_CLK,
    input wire        I_RST_N,
    input wire        I_LOOP_DETECT_IN,
    input wire        I_LATCHING_TRIGGER_IN,
    input wire        I_LOWER_IN,
    input wire [1:0]  I_BATT_LEVEL,
    input wire [1:0]  I_LIGHT_MODE,
    input wire [13:0] I_FAULT_EVT,
    input wire [7:0]  I_ADDR,
    input wire [31:0] I_WDATA,
    input wire        I_WR,
    input wire        I_RD,
    input wire [31:0] O_RDATA,
    input wire        O_LED_LOOP_GRN,
    input wire        O_LED_LATCH_RED,
    input wire        O_LED_LOWER_RED,
    input wire [2:0]  O_BATT_BARS,
    input wire [1:0]  O_LIGHT_FIELD_MODE,
    input wire        O_BUZZER,
    input wire        O_ARM_INHIBIT,
    input wire        O_COLLISION,
    input wire        O_IRQ
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);
    logic [1:0] up; // live edges since reset, saturating at three
    wire live = up == 2'h3; // $past is trusted only from here
    always_ff @(posedge I_CLK)
        up <= !I_RST_N ? 2'h0 : (live ? up : up + 2'h1);
    chk_grn_mirror: assert property (
        live |-> O_LED_LOOP_GRN == !$past(I_LOOP_DETECT_IN))
        else $error("green led wrong");
    chk_red_mirror: assert property (
        live |-> {O_LED_LATCH_RED, O_LED_LOWER_RED} ==
        $past({I_LATCHING_TRIGGER_IN, I_LOWER_IN}))
        else $error("red led wrong");
    chk_batt_bars: assert property (
        live && $stable(I_BATT_LEVEL) |-> O_BATT_BARS ==
        (I_BATT_LEVEL == 2'h0 ? 3'h0 : I_BATT_LEVEL == 2'h1 ? 3'h2 : 3'h4))
        else $error("battery bars wrong");
    chk_light_mode: assert property (
        live |-> O_LIGHT_FIELD_MODE == $past(I_LIGHT_MODE))
        else $error("light field mode wrong");
    chk_rdata_idle: assert property (
        live && !$past(I_RD) |-> O_RDATA == 32'h0000_0000)
        else $error("read data outside a read");
    chk_clear_irq: assert property (
        (I_WR && I_ADDR == `BFA_REG_INT_CLEAR && I_WDATA[13:0] == 14'h3FFF
        && I_FAULT_EVT == 14'h0000) ##1 I_FAULT_EVT == 14'h0000 |=> !O_IRQ)
        else $error("irq after full clear");
    chk_enable_off: assert property (
        I_WR && I_ADDR == `BFA_REG_INT_ENABLE && I_WDATA[13:0] == 14'h0000
        |-> ##2 !O_IRQ)
        else $error("irq while disabled");
    chk_inhibit_evt: assert property (
        |(I_FAULT_EVT & 14'h3F7C) |-> ##2 O_ARM_INHIBIT)
        else $error("no arm inhibit");
    chk_stall_coll: assert property (
        I_FAULT_EVT[`BFA_C_STALL] |-> ##2 O_COLLISION)
        else $error("stall without collision");
    chk_tone_hold: assert property (
        I_FAULT_EVT[`BFA_C_BREAK_IN] |-> ##3 O_BUZZER [*8])
        else $error("break-in tone broken");
endmodule // bfa_chk

bind bfa_annunciator bfa_chk u_chk (.*);

/* File: tb/bfa_field_model.sv */
// field model: barrier contacts and arm position
// assumes commands move just after a rising edge
`timescale 1ns/1ps
module bfa_field_model (
    input  wire        i_clk,
    input  wire  [6:0] i_fin,      // loop, aux, lock, latch, moment, up, dn
    input  wire  [1:0] i_arm,      // 0 lowered, 1 up, 2 raising, 3 lowering
    output logic [6:0] o_fin      = 7'h00,
    output logic       o_lowered  = 1'h1,
    output logic       o_raising  = 1'h0,
    output logic       o_lowering = 1'h0
);
    // contacts settle one clock after a move
    always @(posedge i_clk) begin
        o_fin      <= i_fin;
        o_lowered  <= i_arm == 2'h0;
        o_raising  <= i_arm == 2'h2;
        o_lowering <= i_arm == 2'h3;
    end
endmodule // bfa_field_model

/* File: tb/bfa_annunciator_tb.sv */
// bench for bfa_annunciator: tables, flashes, buzzer, registers
// assumes TICK_CYCLES of 2: one ms tick is two clocks
`timescale 1ns/1ps
`include "bfa_consts.vh"
module bfa_annunciator_tb;
    logic I_CLK = 1'h0, I_RST_N = 1'h0, I_WR = 1'h0, I_RD = 1'h0;
    logic I_LIGHT_OVERRIDE = 1'h0, I_MAINS_OK = 1'h1, I_BATT_LOW = 1'h0;
    logic I_MULTI_COLLISION = 1'h0, I_AUTOLOWER_SEL = 1'h0;
    logic I_AUTOLOWER_OVR = 1'h0;
    logic [1:0]  I_BATT_LEVEL = 2'h3, I_LIGHT_MODE = 2'h0, arm = 2'h0;
    logic [7:0]  I_AUTOLOWER_TIME = 8'h2A, I_COURTESY_TIME = 8'h17;
    logic [7:0]  I_ADDR = 8'h00;
    logic [6:0]  fin = 7'h00;          // field contact commands
    logic [13:0] I_FAULT_EVT = 14'h0000, inh_mask = 14'h3F7C;
    logic [31:0] I_WDATA = 32'h0000_0000;
    logic        inh;                  // expected inhibit
    wire I_LOOP_DETECT_IN, I_AUX_IN, I_LOCK_STOP_IN, I_LATCHING_TRIGGER_IN;
    wire I_MOMENTARY_TRIGGER_IN, I_RAISE_IN, I_LOWER_IN;
    wire I_ARM_LOWERED, I_ARM_RAISING, I_ARM_LOWERING;
    wire O_LED_LOOP_GRN, O_LED_AUX_GRN, O_LED_LOCK_GRN, O_LED_LATCH_RED;
    wire O_LED_MOMENT_RED, O_LED_RAISE_RED, O_LED_LOWER_RED, O_LED_STATUS;
    wire O_BATT_ICON, O_MAINS_SOLID, O_MAINS_HOLLOW, O_BUZZER;
    wire O_ARM_INHIBIT, O_COLLISION, O_IRQ;
    wire [31:0] O_RDATA;
    wire [2:0]  O_BATT_BARS;
    wire [1:0]  O_AUTOLOWER_MODE, O_LIGHT_FIELD_MODE;
    wire [7:0]  O_AUTOLOWER_TIME, O_LIGHT_FIELD_TIME;
    wire [3:0] blink = {O_BUZZER, O_BATT_ICON, O_MAINS_HOLLOW, O_LED_STATUS};
    int miscompares = 0, n_checks = 0;
    int r [4];                         // rises: status, hollow, icon, buzzer
    // {fin, batt, light mode, al sel, al ovr}
    logic [12:0] frow [4] = '{13'h0030, 13'h1FD6, 13'h156B, 13'h0ABD};
    // {leds, bars, al mode}
    logic [11:0] fexp [4] = '{12'hE10, 12'h1EA, 12'h4B1, 12'hB50};
    // {arm, ovr, mains, batt low, coll, batt}
    logic [7:0] srow [9] = '{8'h13, 8'h53, 8'h93, 8'hD3, 8'h73, 8'h43,
                             8'h5B, 8'h54, 8'hAF};
    // rises of status, level (-1 none), hollow, icon
    int sexp [9][4] = '{'{0, 0, 0, 0}, '{0, 1, 0, 0}, '{2, -1, 0, 0},
        '{8, -1, 0, 0}, '{1, -1, 0, 0}, '{2, -1, 2, 0}, '{3, -1, 0, 0},
        '{4, -1, 0, 2}, '{1, -1, 2, 0}};
    int eord [14] = '{0, 1, 7, 2, 3, 4, 5, 6, 8, 9, 10, 11, 12, 13};

    bfa_field_model u_field (
        .i_clk      (I_CLK),
        .i_fin      (fin),
        .i_arm      (arm),
        .o_fin      ({I_LOOP_DETECT_IN, I_AUX_IN, I_LOCK_STOP_IN,
                      I_LATCHING_TRIGGER_IN, I_MOMENTARY_TRIGGER_IN,
                      I_RAISE_IN, I_LOWER_IN}),
        .o_lowered  (I_ARM_LOWERED),
        .o_raising  (I_ARM_RAISING),
        .o_lowering (I_ARM_LOWERING)
    );
    // short tick keeps timers in the run
    bfa_annunciator #(.TICK_CYCLES(2)) dut (.*);

    initial forever #4 I_CLK = ~I_CLK;

    task automatic print_verdict;
        if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmpn(string what, int exp, int got);
        n_checks++;
        if (got != exp) begin
            miscompares++;
            $display("Error %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic rstchk;
        cmp("outputs in reset", 5'h00, {O_BUZZER, O_ARM_INHIBIT,
            O_COLLISION, O_LED_STATUS, O_LED_LOOP_GRN});
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge I_CLK);
        #1;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge I_CLK);
        I_WR <= 1'h1;
        I_ADDR <= a;
        I_WDATA <= d;
        @(posedge I_CLK);
        I_WR <= 1'h0;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] exp, string what);
        @(posedge I_CLK);
        I_RD <= 1'h1;
        I_ADDR <= a;
        @(posedge I_CLK);
        I_RD <= 1'h0;
        #1 cmp(what, exp, O_RDATA);
    endtask
    // returns on the edge that takes the pulse
    task automatic evt(logic [13:0] v);
        @(posedge I_CLK);
        I_FAULT_EVT <= v;
        @(posedge I_CLK);
        I_FAULT_EVT <= 14'h0000;
    endtask
    // count rises over n clocks
    task automatic meas(int n);
        logic [3:0] p, c;
        r = '{0, 0, 0, 0};
        #1 p = blink;
        repeat (n) begin
            @(posedge I_CLK);
            #1 c = blink;
            for (int k = 0; k < 4; k++)
                if (p[k] === 1'h0 && c[k] === 1'h1) r[k]++;
            p = c;
        end
    endtask

    // hang guard
    initial begin
        repeat (90000) @(posedge I_CLK);
        miscompares++;
        print_verdict;
    end

    initial begin
        tick(19);
        rstchk;
        @(posedge I_CLK);
        I_RST_N <= 1'h1;
        // indicator and lcd table
        for (int i = 0; i < 4; i++) begin
            @(posedge I_CLK);
            {fin, I_BATT_LEVEL, I_LIGHT_MODE, I_AUTOLOWER_SEL,
             I_AUTOLOWER_OVR} <= frow[i];
            tick(3);
            cmp("leds", fexp[i][11:5], {O_LED_LOOP_GRN, O_LED_AUX_GRN,
                O_LED_LOCK_GRN, O_LED_LATCH_RED, O_LED_MOMENT_RED,
                O_LED_RAISE_RED, O_LED_LOWER_RED});
            cmp("battery bars", fexp[i][4:2], O_BATT_BARS);
            cmp("autolower mode", fexp[i][1:0], O_AUTOLOWER_MODE);
            cmp("autolower time", fexp[i][1:0] == 2'h2 ? 8'h2A : 8'h00,
                O_AUTOLOWER_TIME);
            cmp("light mode", frow[i][3:2], O_LIGHT_FIELD_MODE);
            cmp("light time", frow[i][3:2] == 2'h0 ? 8'h17 : 8'h00,
                O_LIGHT_FIELD_TIME);
        end
        // status led and icons over one code period
        for (int i = 0; i < 9; i++) begin
            @(posedge I_CLK);
            {arm, I_LIGHT_OVERRIDE, I_MAINS_OK, I_BATT_LOW,
             I_MULTI_COLLISION, I_BATT_LEVEL} <= srow[i];
            tick(500);
            meas(4000);
            cmpn("status flashes", sexp[i][0], r[0]);
            if (sexp[i][1] >= 0)
                cmp("status level", sexp[i][1], O_LED_STATUS);
            cmpn("mains hollow flashes", sexp[i][2], r[1]);
            cmpn("battery icon flashes", sexp[i][3], r[2]);
            cmp("mains solid", srow[i][4], O_MAINS_SOLID);
        end
        // buzzer, irq masking, timer lengths
        wr(`BFA_REG_INT_ENABLE, 32'h0000_0020);
        rd(`BFA_REG_INT_ENABLE, 32'h0000_0020, "enable");
        evt(14'h0040);
        meas(3200);
        cmpn("short beeps", 3, r[3]);
        cmp("inhibit", 1'h1, O_ARM_INHIBIT);
        cmp("masked irq", 1'h0, O_IRQ);
        tick(300);
        evt(14'h0020);
        meas(2800);
        cmpn("winner beeps", 1, r[3]);
        cmp("irq", 1'h1, O_IRQ);
        rd(`BFA_REG_INT_STATUS, 32'h0000_0060, "status");
        wr(`BFA_REG_INT_STATUS, 32'h0000_0000);
        wr(`BFA_REG_INT_CLEAR, 32'h0000_0020);
        rd(`BFA_REG_INT_STATUS, 32'h0000_0040, "status after clear");
        cmp("irq after clear", 1'h0, O_IRQ);
        rd(8'h10, 32'h0000_0000, "unmapped");
        tick(4780);
        rd(`BFA_REG_ACTIVE, 32'h0000_0020, "active");
        tick(2800);
        rd(`BFA_REG_ACTIVE, 32'h0000_0000, "active expired");
        wr(`BFA_REG_INT_CLEAR, 32'hFFFF_FFFF);
        rd(`BFA_REG_INT_STATUS, 32'h0000_0000, "status cleared");
        // each condition; break-in keeps the buzzer
        wr(`BFA_REG_INT_ENABLE, 32'hFFFF_FFFF);
        rd(`BFA_REG_INT_ENABLE, 32'h0000_3FFF, "enable width");
        inh = 1'h0;
        foreach (eord[k]) begin
            evt(14'h0001 << eord[k]);
            inh = inh | inh_mask[eord[k]];
            tick(3);
            cmp("inhibit", inh, O_ARM_INHIBIT);
            cmp("collision", eord[k] == 13, O_COLLISION);
        end
        cmp("irq", 1'h1, O_IRQ);
        rd(`BFA_REG_ACTIVE, 32'h0000_3FFF, "active all");
        meas(2000);
        cmpn("tone breaks", 0, r[3]);
        cmp("tone", 1'h1, O_BUZZER);
        wr(`BFA_REG_INT_ENABLE, 32'h0000_0000);
        tick(2);
        cmp("irq disabled", 1'h0, O_IRQ);
        // mid-run reset
        @(posedge I_CLK);
        I_RST_N <= 1'h0;
        tick(3);
        rstchk;
        @(posedge I_CLK);
        I_RST_N <= 1'h1;
        rd(`BFA_REG_ACTIVE, 32'h0000_0000, "active after reset");
        rd(`BFA_REG_INT_ENABLE, 32'h0000_0000, "enable after reset");
        print_verdict;
    end
endmodule // bfa_annunciator_tb
